//--- att_pkg.sv
// constants, field layouts and types of the acquisition trigger timing block
package att_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCAN_HIGH_NS  = 4000;
	localparam int STROBE_LOW_NS = 500;
	localparam int SCAN_HIGH_CYC = (SCAN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SCAN_HIGH_CNT  = 8'(SCAN_HIGH_CYC);
	localparam logic [7:0] STROBE_LOW_CNT = 8'(STROBE_LOW_CYC);

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_CMD      = 8'h04;
	localparam logic [7:0] OFS_STROBE   = 8'h08;
	localparam logic [7:0] OFS_SAMPLES  = 8'h0C;
	localparam logic [7:0] OFS_INTERVAL = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_DAC0     = 8'h18;
	localparam logic [7:0] OFS_DAC1     = 8'h1C;

	////////////////////////////////////////////////////////////////////////////////
	// field positions and widths
	localparam int CTRL_W          = 8;
	localparam int CNT_W           = 16;
	localparam int DAC_W           = 12;
	localparam int CMD_START_BIT   = 0;
	localparam int CMD_ABORT_BIT   = 1;
	localparam int CMD_DAC_UPD_BIT = 2;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [15:0] SAMPLES_RST  = 16'h0001;
	localparam logic [15:0] INTERVAL_RST = 16'h0064;
	localparam logic [11:0] DAC_RST      = 12'h000;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic ext_wave_mode;
		logic update_route_ctrl;
		logic posted_update;
		logic ext_conv_select;
		logic ext_trig_inhibit;
		logic pretrig_mode;
		logic sw_gate_open;
		logic scan_enable;
	} att_ctrl_t;

	typedef struct packed {
		logic [15:0] samples_left;
		logic [11:0] reserved;
		logic        gate_level;
		logic        trigger_level;
		logic        counting;
		logic        active;
	} att_status_t;

	typedef enum logic [1:0] {
		ACQ_IDLE,
		ACQ_PRE,
		ACQ_RUN
	} att_acq_t;

endpackage

//--- att_sync_fall.sv
// two-stage synchroniser with falling-edge detect for one timing input
`timescale 1ns/1ps
module att_sync_fall (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      level,
	output logic      fall
);

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	////////////////////////////////////////////////////////////////////////////////
	// idle level of the pins is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign fall  = prev_ff & ~sync_ff;

endmodule // att_sync_fall

//--- att_timing.sv
// acquisition trigger timing block with apb register slave
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module att_timing (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_trigger_n,
	input  wire logic        ext_gate_n,
	input  wire logic        ext_convert_n_in,
	output logic             ext_convert_n_out,
	output logic             ext_convert_oe_n,
	input  wire logic        ext_dac_update_n,
	output logic             scan_clock_out,
	output logic             ext_strobe_n,
	output logic             adc_convert,
	output logic             dac_load,
	output logic [11:0]      dac0_value,
	output logic [11:0]      dac1_value,
	output logic             acq_active
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = (v == 16'h0000) ? 16'h0000 : 16'(v - 16'h0001);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	att_pkg::att_ctrl_t   ctrl_ff;
	att_pkg::att_acq_t    acq_ff;
	att_pkg::att_acq_t    nxt_acq;
	att_pkg::att_status_t status;
	logic [15:0]          samples_ff;
	logic [15:0]          interval_ff;
	logic [15:0]          smp_cnt_ff;
	logic [15:0]          ivl_cnt_ff;
	logic [11:0]          dac0_hold_ff;
	logic [11:0]          dac1_hold_ff;
	logic [11:0]          dac0_ff;
	logic [11:0]          dac1_ff;
	logic [31:0]          prdata_ff;
	logic                 pready_ff;
	logic                 pslverr_ff;
	logic [7:0]           scan_cnt_ff;
	logic                 scan_ff;
	logic [7:0]           strobe_cnt_ff;
	logic                 strobe_n_ff;
	logic                 conv_ff;
	logic                 conv_out_ff;
	logic                 conv_oe_n_ff;
	logic                 dac_load_ff;
	logic                 active_ff;
	logic                 trig_level;
	logic                 trig_fall;
	logic                 gate_level;
	logic                 conv_level;
	logic                 conv_fall;
	logic                 upd_fall;
	logic                 access;
	logic                 wr;
	logic                 mapped;
	logic                 sw_start;
	logic                 sw_abort;
	logic                 sw_dac_upd;
	logic                 trigger;
	logic                 seq_start;
	logic                 active;
	logic                 ivl_tick;
	logic                 conv_req;
	logic                 conv_go;
	logic                 smp_done;
	logic                 ext_dac_upd;
	logic                 dac_upd;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers

	att_sync_fall u_sync_trig (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ext_trigger_n),
		.level    (trig_level),
		.fall     (trig_fall)
	);

	att_sync_fall u_sync_gate (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ext_gate_n),
		.level    (gate_level),
		.fall     ()
	);

	att_sync_fall u_sync_conv (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ext_convert_n_in),
		.level    (conv_level),
		.fall     (conv_fall)
	);

	att_sync_fall u_sync_upd (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ext_dac_update_n),
		.level    (),
		.fall     (upd_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// apb decode: one wait state, access completes when pready_ff is high

	assign access = psel & penable & pready_ff;
	assign wr     = access & pwrite;
	assign mapped = hit(paddr, att_pkg::OFS_CTRL) | hit(paddr, att_pkg::OFS_CMD) |
		hit(paddr, att_pkg::OFS_STROBE) | hit(paddr, att_pkg::OFS_SAMPLES) |
		hit(paddr, att_pkg::OFS_INTERVAL) | hit(paddr, att_pkg::OFS_STATUS) |
		hit(paddr, att_pkg::OFS_DAC0) | hit(paddr, att_pkg::OFS_DAC1);

	assign sw_start   = wr & hit(paddr, att_pkg::OFS_CMD) & pwdata[att_pkg::CMD_START_BIT];
	assign sw_abort   = wr & hit(paddr, att_pkg::OFS_CMD) & pwdata[att_pkg::CMD_ABORT_BIT];
	assign sw_dac_upd = wr & hit(paddr, att_pkg::OFS_CMD) & pwdata[att_pkg::CMD_DAC_UPD_BIT];

	always_comb begin
		status               = '0;
		status.samples_left  = smp_cnt_ff;
		status.gate_level    = gate_level;
		status.trigger_level = trig_level;
		status.counting      = (acq_ff == att_pkg::ACQ_RUN);
		status.active        = active_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
			if (psel & penable & ~pready_ff & ~pwrite) begin
				case (paddr)
					att_pkg::OFS_CTRL:     prdata_ff <= {24'h000000, ctrl_ff};
					att_pkg::OFS_SAMPLES:  prdata_ff <= {16'h0000, samples_ff};
					att_pkg::OFS_INTERVAL: prdata_ff <= {16'h0000, interval_ff};
					att_pkg::OFS_STATUS:   prdata_ff <= status;
					att_pkg::OFS_DAC0:     prdata_ff <= {20'h00000, dac0_hold_ff};
					att_pkg::OFS_DAC1:     prdata_ff <= {20'h00000, dac1_hold_ff};
					default:               prdata_ff <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff     <= att_pkg::CTRL_RST;
			samples_ff  <= att_pkg::SAMPLES_RST;
			interval_ff <= att_pkg::INTERVAL_RST;
		end else if (wr) begin
			if (hit(paddr, att_pkg::OFS_CTRL))
				ctrl_ff <= att_pkg::att_ctrl_t'(pwdata[att_pkg::CTRL_W-1:0]);
			if (hit(paddr, att_pkg::OFS_SAMPLES))
				samples_ff <= pwdata[att_pkg::CNT_W-1:0];
			if (hit(paddr, att_pkg::OFS_INTERVAL))
				interval_ff <= pwdata[att_pkg::CNT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// triggering and acquisition sequence

	assign trigger = (trig_fall & ~ctrl_ff.ext_trig_inhibit) |
		(sw_start & trig_level);
	assign active    = (acq_ff != att_pkg::ACQ_IDLE);
	assign seq_start = (acq_ff == att_pkg::ACQ_IDLE) & trigger;
	assign smp_done  = (acq_ff == att_pkg::ACQ_RUN) & conv_go & (smp_cnt_ff <= 16'h0001);

	always_comb begin
		nxt_acq = acq_ff;
		case (acq_ff)
			att_pkg::ACQ_IDLE: begin
				if (trigger)
					nxt_acq = ctrl_ff.pretrig_mode ? att_pkg::ACQ_PRE : att_pkg::ACQ_RUN;
			end
			att_pkg::ACQ_PRE: begin
				if (trigger)
					nxt_acq = att_pkg::ACQ_RUN;
			end
			att_pkg::ACQ_RUN: begin
				if (smp_done)
					nxt_acq = att_pkg::ACQ_IDLE;
			end
			default: nxt_acq = att_pkg::ACQ_IDLE;
		endcase
		if (sw_abort)
			nxt_acq = att_pkg::ACQ_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_ff    <= att_pkg::ACQ_IDLE;
			active_ff <= 1'b0;
		end else begin
			acq_ff    <= nxt_acq;
			active_ff <= (nxt_acq != att_pkg::ACQ_IDLE);
		end
	end

	// sample counter loads when counting begins, counts only in the run state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smp_cnt_ff <= 16'h0000;
		end else if (acq_ff != att_pkg::ACQ_RUN && nxt_acq == att_pkg::ACQ_RUN) begin
			smp_cnt_ff <= samples_ff;
		end else if (acq_ff == att_pkg::ACQ_RUN && conv_go) begin
			smp_cnt_ff <= dec16(smp_cnt_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sample-interval counter and the shared convert line

	assign ivl_tick = active & (ivl_cnt_ff <= 16'h0001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ivl_cnt_ff <= 16'h0000;
		end else if (seq_start) begin
			ivl_cnt_ff <= interval_ff;
		end else if (ivl_tick) begin
			ivl_cnt_ff <= interval_ff;
		end else if (active) begin
			ivl_cnt_ff <= dec16(ivl_cnt_ff);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_out_ff  <= 1'b1;
			conv_oe_n_ff <= 1'b1;
		end else begin
			conv_oe_n_ff <= ctrl_ff.ext_conv_select;
			conv_out_ff  <= ~(ivl_tick & ~ctrl_ff.ext_conv_select);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// conversion gating and start pulse

	assign conv_req = ctrl_ff.ext_conv_select ? (conv_fall & ~conv_level) : ivl_tick;
	assign conv_go  = conv_req & active & gate_level & ctrl_ff.sw_gate_open;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_ff <= 1'b0;
		end else begin
			conv_ff <= conv_go;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// scan clock

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_ff     <= 1'b0;
			scan_cnt_ff <= 8'h00;
		end else if (!ctrl_ff.scan_enable) begin
			scan_ff     <= 1'b0;
			scan_cnt_ff <= 8'h00;
		end else if (conv_go) begin
			scan_ff     <= 1'b1;
			scan_cnt_ff <= att_pkg::SCAN_HIGH_CNT;
		end else if (scan_cnt_ff > 8'h01) begin
			scan_cnt_ff <= 8'(scan_cnt_ff - 8'h01);
		end else begin
			scan_ff     <= 1'b0;
			scan_cnt_ff <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// external strobe

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_n_ff   <= 1'b1;
			strobe_cnt_ff <= 8'h00;
		end else if (access & hit(paddr, att_pkg::OFS_STROBE)) begin
			strobe_n_ff   <= 1'b0;
			strobe_cnt_ff <= att_pkg::STROBE_LOW_CNT;
		end else if (strobe_cnt_ff > 8'h01) begin
			strobe_cnt_ff <= 8'(strobe_cnt_ff - 8'h01);
		end else begin
			strobe_n_ff   <= 1'b1;
			strobe_cnt_ff <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output converter update

	assign ext_dac_upd = upd_fall & ctrl_ff.posted_update & ~ctrl_ff.update_route_ctrl &
		ctrl_ff.ext_wave_mode;
	assign dac_upd = ctrl_ff.posted_update & (ext_dac_upd | sw_dac_upd);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac0_hold_ff <= att_pkg::DAC_RST;
			dac1_hold_ff <= att_pkg::DAC_RST;
		end else if (wr) begin
			if (hit(paddr, att_pkg::OFS_DAC0))
				dac0_hold_ff <= pwdata[att_pkg::DAC_W-1:0];
			if (hit(paddr, att_pkg::OFS_DAC1))
				dac1_hold_ff <= pwdata[att_pkg::DAC_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac0_ff     <= att_pkg::DAC_RST;
			dac1_ff     <= att_pkg::DAC_RST;
			dac_load_ff <= 1'b0;
		end else if (dac_upd) begin
			dac0_ff     <= dac0_hold_ff;
			dac1_ff     <= dac1_hold_ff;
			dac_load_ff <= 1'b1;
		end else if (!ctrl_ff.posted_update && wr &&
			(hit(paddr, att_pkg::OFS_DAC0) || hit(paddr, att_pkg::OFS_DAC1))) begin
			if (hit(paddr, att_pkg::OFS_DAC0))
				dac0_ff <= pwdata[att_pkg::DAC_W-1:0];
			if (hit(paddr, att_pkg::OFS_DAC1))
				dac1_ff <= pwdata[att_pkg::DAC_W-1:0];
			dac_load_ff <= 1'b1;
		end else begin
			dac_load_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata            = prdata_ff;
	assign pready            = pready_ff;
	assign pslverr           = pslverr_ff;
	assign ext_convert_n_out = conv_out_ff;
	assign ext_convert_oe_n  = conv_oe_n_ff;
	assign scan_clock_out    = scan_ff;
	assign ext_strobe_n      = strobe_n_ff;
	assign adc_convert       = conv_ff;
	assign dac_load          = dac_load_ff;
	assign dac0_value        = dac0_ff;
	assign dac1_value        = dac1_ff;
	assign acq_active        = active_ff;

endmodule // att_timing

//--- att_timing_props.sv
// concurrent checks on the acquisition trigger timing ports
`timescale 1ns/1ps
module att_timing_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        ext_gate_n,
	input wire logic        ext_convert_n_out,
	input wire logic        ext_convert_oe_n,
	input wire logic        scan_clock_out,
	input wire logic        ext_strobe_n,
	input wire logic        adc_convert,
	input wire logic        dac_load,
	input wire logic [11:0] dac0_value,
	input wire logic [11:0] dac1_value,
	input wire logic        acq_active
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// cycles the scan clock has stayed high since the last conversion
	logic [7:0] run_ff;
	logic [7:0] nxt_run;
	assign nxt_run = adc_convert ? 8'h00 : (scan_clock_out ? run_ff + 8'h01 : 8'h00);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) run_ff <= 8'h00;
		else run_ff <= nxt_run;
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_acc;
		psel && penable && pready;
	endsequence
	sequence s_strobe;
		s_acc ##0 (paddr == att_pkg::OFS_STROBE);
	endsequence

	AST_STROBE_LOW: assert property (s_strobe |=> !ext_strobe_n [*5])
		else $error("strobe pulse too short");
	AST_SCAN_RISE: assert property ($rose(scan_clock_out) |-> adc_convert)
		else $error("scan rose without conversion");
	AST_SCAN_HOLD: assert property (adc_convert && scan_clock_out |=> scan_clock_out [*8])
		else $error("scan pulse too short");
	AST_SCAN_LEN: assert property (scan_clock_out && !adc_convert |-> run_ff < 8'h29)
		else $error("scan pulse too long");
	AST_CONV_ACTIVE: assert property (adc_convert |-> $past(acq_active))
		else $error("conversion outside sequence");
	AST_GATE_BLOCK: assert property (!ext_gate_n [*4] |=> !adc_convert)
		else $error("conversion while gate low");
	AST_LINE_OWN: assert property (!ext_convert_n_out |-> !ext_convert_oe_n)
		else $error("convert line pulled while released");
	AST_DAC_LOAD: assert property ($changed(dac0_value) || $changed(dac1_value) |-> dac_load)
		else $error("dac changed without load");
	AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
endmodule // att_timing_props

bind att_timing att_timing_props att_timing_props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .ext_gate_n(ext_gate_n), .ext_convert_n_out(ext_convert_n_out),
	.ext_convert_oe_n(ext_convert_oe_n), .scan_clock_out(scan_clock_out),
	.ext_strobe_n(ext_strobe_n), .adc_convert(adc_convert), .dac_load(dac_load),
	.dac0_value(dac0_value), .dac1_value(dac1_value), .acq_active(acq_active)
);

//--- att_ext_model.sv
// external instrument model driving the timing pins
`timescale 1ns/1ps
module att_ext_model (
	input  wire logic pclk,
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	output logic      trig_n,
	output logic      gate_n,
	output logic      conv_line,
	output logic      upd_n
);
	logic conv_n;
	// pulled-up shared line; the model only pulses it while the device is off it
	assign conv_line = !dev_oe_n ? dev_out : conv_n;
	initial begin
		trig_n = 1'b1;
		gate_n = 1'b1;
		conv_n = 1'b1;
		upd_n = 1'b1;
	end
	task automatic put(input int k, input logic v);
		case (k)
			0: trig_n <= v;
			1: conv_n <= v;
			2: upd_n <= v;
			default: gate_n <= v;
		endcase
	endtask
	// high lead before each fall, then two cycles low
	task automatic pulse(input int k);
		repeat (k == 1 ? 45 : 2) @(posedge pclk);
		put(k, 1'b0);
		repeat (2) @(posedge pclk);
		put(k, 1'b1);
	endtask
endmodule // att_ext_model

//--- test_acquisition_trigger_timing.sv
// self-checking bench for the acquisition trigger timing block
`timescale 1ns/1ps
module test_acquisition_trigger_timing;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        rerr;
	logic        trig_n;
	logic        gate_n;
	logic        conv_line;
	logic        upd_n;
	logic        conv_out;
	logic        conv_oe_n;
	logic        scan;
	logic        strobe_n;
	logic        adc;
	logic [11:0] dac0;
	logic [11:0] dac1;
	logic        dload;
	logic [11:0] ed;
	logic        active;
	logic [31:0] rdat;
	logic [31:0] exp_reg [8];
	logic [7:0]  rofs [4] = '{8'h0C, 8'h10, 8'h18, 8'h1C};
	logic [7:0]  cctl [5] = '{8'h03, 8'h02, 8'h01, 8'h03, 8'h0B};
	logic [7:0]  dctl [3] = '{8'hA0, 8'hE0, 8'h20};
	logic        cgate [5] = '{1, 1, 1, 0, 1};
	logic        cact [5] = '{0, 0, 1, 1, 0};
	int          cconv [5] = '{2, 2, 0, 0, 0};
	int          error_cnt;
	int          total_checks;
	int          conv_cnt;
	int          scan_cnt;
	int          ld_cnt;
	int          k;
	int          seed;

	att_timing att_timing_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(rerr), .ext_trigger_n(trig_n), .ext_gate_n(gate_n),
		.ext_convert_n_in(conv_line), .ext_convert_n_out(conv_out),
		.ext_convert_oe_n(conv_oe_n), .ext_dac_update_n(upd_n), .scan_clock_out(scan),
		.ext_strobe_n(strobe_n), .adc_convert(adc), .dac_load(dload), .dac0_value(dac0),
		.dac1_value(dac1), .acq_active(active));
	att_ext_model att_ext_model_i (.pclk(pclk), .dev_out(conv_out), .dev_oe_n(conv_oe_n),
		.trig_n(trig_n), .gate_n(gate_n), .conv_line(conv_line), .upd_n(upd_n));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (adc === 1'b1) conv_cnt++;
		if (scan === 1'b1) scan_cnt++;
		if (dload === 1'b1) ld_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tout();
		chk("wait", 0, 1);
		wrap_up();
	endtask
	function automatic logic [31:0] msk(input logic [7:0] a);
		case (a)
			8'h00: return 32'h0000_00FF;
			8'h0C, 8'h10: return 32'h0000_FFFF;
			8'h18, 8'h1C: return 32'h0000_0FFF;
			default: return 32'h0;
		endcase
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) tout();
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		exp_reg[a[4:2]] = d & msk(a);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk("register", rdat, exp_reg[a[4:2]]);
	endtask
	task automatic idle(input int b);
		int n;
		for (n = 0; n < b && active !== 1'b0; n++) @(posedge pclk);
		if (n == b) tout();
		repeat (50) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hE87D;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		exp_reg = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h64, 32'h0, 32'h0, 32'h0};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (i != 5) rd(8'(i * 4));
		end
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		chk("slverr", rerr, 1'b1);
		rd(8'h00);
		foreach (rofs[i]) begin
			wr(rofs[i], $random(seed));
			rd(rofs[i]);
		end
		chk("dac0", dac0, exp_reg[6][11:0]);
		chk("dac1", dac1, exp_reg[7][11:0]);
		for (int w = 0; w < 2; w++) begin
			apb(w[0], 8'h08, 32'h0);
			k = 0;
			repeat (10) begin
				@(posedge pclk);
				if (strobe_n === 1'b0) k++;
			end
			chk("strobe low", k, 5);
		end
		wr(8'h0C, 32'h2);
		wr(8'h10, 32'h6);
		for (int i = 0; i < 5; i++) begin
			wr(8'h00, cctl[i]);
			att_ext_model_i.put(3, cgate[i]);
			conv_cnt = 0;
			scan_cnt = 0;
			att_ext_model_i.pulse(0);
			repeat (80) @(posedge pclk);
			chk("conversions", conv_cnt, cconv[i]);
			chk("scan used", scan_cnt, i == 0 ? 6 + att_pkg::SCAN_HIGH_CYC : 0);
			chk("active", active, cact[i]);
			chk("line owner", conv_oe_n, 1'b0);
			wr(8'h04, 32'h2);
			@(posedge pclk);
			chk("abort", active, 1'b0);
		end
		att_ext_model_i.put(3, 1'b1);
		for (int v = 0; v < 2; v++) begin
			att_ext_model_i.put(0, v[0]);
			repeat (4) @(posedge pclk);
			wr(8'h04, 32'h1);
			repeat (2) @(posedge pclk);
			chk("soft start", active, v[0]);
			wr(8'h04, 32'h2);
		end
		wr(8'h00, 32'h07);
		wr(8'h10, 32'h14);
		conv_cnt = 0;
		att_ext_model_i.pulse(0);
		repeat (60) @(posedge pclk);
		chk("pre run", active, 1'b1);
		chk("pre conv", conv_cnt >= 2, 1'b1);
		conv_cnt = 0;
		att_ext_model_i.pulse(0);
		idle(200);
		chk("post conv", conv_cnt == 2 || conv_cnt == 3, 1'b1);
		wr(8'h00, 32'h13);
		wr(8'h10, 32'h3E8);
		repeat (2) @(posedge pclk);
		chk("line released", conv_oe_n, 1'b1);
		conv_cnt = 0;
		att_ext_model_i.pulse(0);
		repeat (20) @(posedge pclk);
		chk("no tick", conv_cnt, 0);
		repeat (2) att_ext_model_i.pulse(1);
		idle(200);
		chk("ext conv", conv_cnt, 2);
		ed = exp_reg[6][11:0];
		ld_cnt = 0;
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, dctl[i]);
			wr(8'h18, $random(seed));
			wr(8'h1C, $random(seed));
			chk("dac hold", dac0, ed);
			att_ext_model_i.pulse(2);
			repeat (6) @(posedge pclk);
			if (i == 0) ed = exp_reg[6][11:0];
			chk("dac ext", dac0, ed);
			wr(8'h04, 32'h4);
			ed = exp_reg[6][11:0];
			repeat (2) @(posedge pclk);
			chk("dac cmd", dac0, ed);
			chk("dac1 cmd", dac1, exp_reg[7][11:0]);
		end
		chk("dac loads", ld_cnt, 4);
		wrap_up();
	end
endmodule // test_acquisition_trigger_timing
